// >>> fcsl_cfg.svh
/*
 * Constants for the sector-map and register-latency block: bit positions,
 * reset values, latency figures, address-map bounds and host register offsets.
 * Assumes inclusion from fcsl_pkg and from the testbench.
 */
// Summary of operation
// (RULE_01) Map bit: 0 hybrid, 1 uniform.
// (RULE_02) Hybrid map includes the small-sector group.
// (RULE_03) Small group sits top or bottom.
// (RULE_04) Uniform map removes small sectors entirely.
// (RULE_05) Small-sector erase runs only in hybrid.
// (RULE_06) Small-sector erase ignored while uniform.
// (RULE_07) Host writes reserved low bits as zero.
// (RULE_08) Code 00: single 0, octal 3.
// (RULE_09) Code 01: single 1 or 0, octal 4.
// (RULE_10) Code 10: single 1, octal 5.
// (RULE_11) Code 11: single 2, octal 6.
// (RULE_12) Unique-identifier reads always take 32 cycles.
// (RULE_13) CRC-result read always takes 8 cycles.
// (RULE_14) Volatile read-any-register uses coded latency.
// (RULE_15) Bits 7:6 set register-read latency.
// (RULE_16) Volatile map bit read-only; layout follows it.
`ifndef FCSL_CFG_SVH
`define FCSL_CFG_SVH

`define FCSL_CFG_RESET      8'h00
`define FCSL_LAT_MSB        7
`define FCSL_LAT_LSB        6
`define FCSL_MAP_BIT        3
`define FCSL_RSVD_MSB       2
`define FCSL_UID_DUMMY      6'h20
`define FCSL_CRC_DUMMY      6'h08
`define FCSL_NV_RD_DUMMY    6'h08
`define FCSL_OCT_BASE       6'h03
`define FCSL_ADDR_W         25
`define FCSL_SMALL_BYTES    25'h0020000
`define FCSL_SMALL_HALF     25'h0010000
`define FCSL_TOP_FULL       25'h1fe0000
`define FCSL_TOP_HALF       25'h1ff0000

`define FCSL_OFS_CMD        4'h0
`define FCSL_OFS_ADDR       4'h4
`define FCSL_OFS_STAT       4'h8

`endif

// >>> fcsl_pkg.sv
/*
 * Types and shared decode functions for both ends of the link.
 * Assumes fcsl_cfg.svh is on the include path.
 */
package fcsl_pkg;
`include "fcsl_cfg.svh"

   typedef enum logic [2:0]
   {
      FCSL_OP_RD_ANY,
      FCSL_OP_RD_DYB,
      FCSL_OP_RD_STAT,
      FCSL_OP_RD_UID,
      FCSL_OP_RD_CRC,
      FCSL_OP_WR_REG,
      FCSL_OP_ERASE_SMALL,
      FCSL_OP_RELOAD
   } fcsl_op_t;

   typedef enum logic [1:0]
   {
      FCSL_MODE_SPI,
      FCSL_MODE_OSDR,
      FCSL_MODE_ODDR
   } fcsl_mode_t;

   // Dummy cycles for a transaction; both ends must agree on this table.
   function automatic logic [5:0] fcsl_dummy(input fcsl_op_t op, input fcsl_mode_t mode,
                                             input logic [1:0] code, input logic nv);
      logic [5:0] n;
      n = 6'h00;
      if (op == FCSL_OP_RD_UID)
         n = `FCSL_UID_DUMMY;                                          // [RULE_12]
      else if (op == FCSL_OP_RD_CRC)
         n = `FCSL_CRC_DUMMY;                                          // [RULE_13]
      else if (op == FCSL_OP_RD_ANY && nv)
         n = `FCSL_NV_RD_DUMMY;
      else if (op == FCSL_OP_RD_ANY || op == FCSL_OP_RD_DYB || op == FCSL_OP_RD_STAT)
      begin
         if (mode != FCSL_MODE_SPI)
            n = `FCSL_OCT_BASE + {4'h0, code};            // [RULE_08] [RULE_09] [RULE_10] [RULE_11]
         else if (code == 2'h3)
            n = 6'h02;                                                 // [RULE_11]
         else if (code == 2'h2)
            n = 6'h01;                                                 // [RULE_10]
         else if (code == 2'h1 && op != FCSL_OP_RD_STAT)
            n = 6'h01;                                      // [RULE_09] [RULE_14]
         else
            n = 6'h00;                                                 // [RULE_08]
      end
      return n;
   endfunction

   // Whether an address falls in the small-sector group of the hybrid map.
   function automatic logic fcsl_in_small(input logic [`FCSL_ADDR_W-1:0] a,
                                          input logic split, input logic top);
      logic hit;
      hit = 1'b0;
      if (split)
         hit = (a < `FCSL_SMALL_HALF) || (a >= `FCSL_TOP_HALF);         // [RULE_03]
      else if (top)
         hit = (a >= `FCSL_TOP_FULL);                                  // [RULE_03]
      else
         hit = (a < `FCSL_SMALL_BYTES);                                // [RULE_03]
      return hit;
   endfunction

endpackage

// >>> fcsl_link_if.sv
/*
 * Transaction link between the host controller and the flash device.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ns
interface fcsl_link_if;
   import fcsl_pkg::*;
   logic                     req;
   fcsl_op_t                 op;
   fcsl_mode_t               mode;
   logic                     nv_target;
   logic [`FCSL_ADDR_W-1:0]  addr;
   logic [7:0]               wdata;
   logic                     rsp;
   logic [7:0]               rdata;

   modport dev
   (
      input  req,
      input  op,
      input  mode,
      input  nv_target,
      input  addr,
      input  wdata,
      output rsp,
      output rdata
   );

   modport host
   (
      output req,
      output op,
      output mode,
      output nv_target,
      output addr,
      output wdata,
      input  rsp,
      input  rdata
   );
endinterface

// >>> fcsl_device.sv
/*
 * Device end: the two copies of configuration register 3, the sector-map
 * layout it selects, small-sector erase gating and register-read latency.
 * Assumes the host sends one request at a time and waits for its answer.
 */
`timescale 1ns/1ns
module fcsl_device
   import fcsl_pkg::*;
(
   input  wire logic                     clk_sys_i,
   input  wire logic                     nrst_i,
   fcsl_link_if.dev                      link,
   input  wire logic                     split_select_i,
   input  wire logic                     top_bottom_select_i,
   input  wire logic [`FCSL_ADDR_W-1:0]  lookup_addr_i,
   output logic                          lookup_small_o,
   output logic                          layout_uniform_o,
   output logic [1:0]                    latency_code_o,
   output logic                          erase_small_o,
   output logic [`FCSL_ADDR_W-1:0]       erase_addr_o
);

   typedef enum logic
   {
      FCSL_DEV_IDLE,
      FCSL_DEV_DUMMY
   } fcsl_dev_state_t;

   fcsl_dev_state_t             state;
   fcsl_dev_state_t             next_state;
   logic [7:0]                  config3_nonvolatile;
   logic [7:0]                  next_config3_nonvolatile;
   logic [7:0]                  config3_volatile;
   logic [7:0]                  next_config3_volatile;
   logic                        load_pend;
   logic                        next_load_pend;
   logic [5:0]                  cnt;
   logic [5:0]                  next_cnt;
   logic                        rsp;
   logic                        next_rsp;
   logic [7:0]                  rdata;
   logic [7:0]                  next_rdata;
   logic                        lookup_small;
   logic                        next_lookup_small;
   logic                        erase_small;
   logic                        next_erase_small;
   logic [`FCSL_ADDR_W-1:0]     erase_addr;
   logic [`FCSL_ADDR_W-1:0]     next_erase_addr;
   logic [5:0]                  dummy;
   logic                        sector_map_select;

   assign sector_map_select = config3_volatile[`FCSL_MAP_BIT];           // [RULE_16]
   assign dummy = fcsl_dummy(link.op, link.mode,
                             config3_volatile[`FCSL_LAT_MSB:`FCSL_LAT_LSB],
                             link.nv_target);                            // [RULE_15]

   always_comb
   begin
      next_state               = state;
      next_config3_nonvolatile = config3_nonvolatile;
      next_config3_volatile    = config3_volatile;
      next_load_pend           = 1'b0;
      next_cnt                 = cnt;
      next_rsp                 = 1'b0;
      next_rdata               = rdata;
      next_erase_small         = 1'b0;
      next_erase_addr          = erase_addr;
      // Small sectors exist in the map only while the hybrid layout is active.
      next_lookup_small = !sector_map_select
                          && fcsl_in_small(lookup_addr_i, split_select_i,
                                           top_bottom_select_i); // [RULE_01] [RULE_02] [RULE_04]

      // The volatile copy is loaded from the non-volatile one after reset.
      if (load_pend)
      begin
         next_config3_volatile = config3_nonvolatile;                    // [RULE_16]
      end

      unique case (state)
         FCSL_DEV_IDLE:
         begin
            if (link.req)
            begin
               unique case (link.op)
                  FCSL_OP_RD_ANY:
                  begin
                     next_rdata = link.nv_target ? config3_nonvolatile
                                                 : config3_volatile;    // [RULE_14]
                  end
                  FCSL_OP_WR_REG:
                  begin
                     if (link.nv_target)
                     begin
                        next_config3_nonvolatile = link.wdata;           // [RULE_16]
                     end
                     else
                     begin
                        // The map bit cannot change here; a reload is the only way.
                        next_config3_volatile = {link.wdata[7:4], sector_map_select,
                                                 link.wdata[`FCSL_RSVD_MSB:0]}; // [RULE_16]
                     end
                     next_rdata = 8'h00;
                  end
                  FCSL_OP_ERASE_SMALL:
                  begin
                     if (!sector_map_select)
                     begin
                        next_erase_small = 1'b1;                         // [RULE_05]
                        next_erase_addr  = link.addr;
                     end
                     // Under the uniform layout the command is dropped silently.
                     next_rdata = 8'h00;                                 // [RULE_06]
                  end
                  FCSL_OP_RELOAD:
                  begin
                     next_config3_volatile = config3_nonvolatile;        // [RULE_16]
                     next_rdata            = 8'h00;
                  end
                  default:
                  begin
                     next_rdata = 8'h00;
                  end
               endcase
               if (dummy == 6'h00)
               begin
                  next_rsp = 1'b1;
               end
               else
               begin
                  next_cnt   = dummy;                 // [RULE_08] [RULE_12] [RULE_13]
                  next_state = FCSL_DEV_DUMMY;
               end
            end
         end
         FCSL_DEV_DUMMY:
         begin
            next_cnt = cnt - 6'h01;
            if (cnt == 6'h01)
            begin
               next_rsp   = 1'b1;
               next_state = FCSL_DEV_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state               <= FCSL_DEV_IDLE;
         config3_nonvolatile <= `FCSL_CFG_RESET;
         config3_volatile    <= `FCSL_CFG_RESET;
         load_pend           <= 1'b1;
         cnt                 <= 6'h00;
         rsp                 <= 1'b0;
         rdata               <= 8'h00;
         lookup_small        <= 1'b0;
         erase_small         <= 1'b0;
         erase_addr          <= '0;
      end
      else
      begin
         state               <= next_state;
         config3_nonvolatile <= next_config3_nonvolatile;
         config3_volatile    <= next_config3_volatile;
         load_pend           <= next_load_pend;
         cnt                 <= next_cnt;
         rsp                 <= next_rsp;
         rdata               <= next_rdata;
         lookup_small        <= next_lookup_small;
         erase_small         <= next_erase_small;
         erase_addr          <= next_erase_addr;
      end
   end

   assign link.rsp         = rsp;
   assign link.rdata       = rdata;
   assign lookup_small_o   = lookup_small;
   assign layout_uniform_o = sector_map_select;
   assign latency_code_o   = config3_volatile[`FCSL_LAT_MSB:`FCSL_LAT_LSB];
   assign erase_small_o    = erase_small;
   assign erase_addr_o     = erase_addr;

endmodule

// >>> fcsl_host.sv
/*
 * Host end: an Avalon-MM slave that launches link transactions, keeps a
 * shadow of the device latency code and checks the answer's timing.
 * Assumes the device answers each request once, after its dummy cycles.
 */
`timescale 1ns/1ns
module fcsl_host
   import fcsl_pkg::*;
(
   input  wire logic         clk_sys_i,
   input  wire logic         nrst_i,
   fcsl_link_if.host         link,
   input  wire logic [3:0]   avs_address_i,
   input  wire logic         avs_read_i,
   input  wire logic         avs_write_i,
   input  wire logic [31:0]  avs_writedata_i,
   input  wire logic [3:0]   avs_byteenable_i,
   output logic [31:0]       avs_readdata_o,
   output logic              avs_waitrequest_o
);

   logic                     waitreq, next_waitreq;
   logic [31:0]              readdata, next_readdata;
   logic                     req, next_req;
   fcsl_op_t                 op, next_op;
   fcsl_mode_t               mode, next_mode;
   logic                     nv_t, next_nv_t;
   logic [`FCSL_ADDR_W-1:0]  addr, next_addr;
   logic [7:0]               wdata, next_wdata;
   logic                     busy, next_busy;
   logic                     err, next_err;
   logic [5:0]               expect_cnt, next_expect_cnt;
   logic [5:0]               elapsed, next_elapsed;
   logic [5:0]               last_cnt, next_last_cnt;
   logic [7:0]               rdata, next_rdata;
   logic [1:0]               code_v, next_code_v;
   logic [1:0]               code_nv, next_code_nv;
   logic                     do_wr;
   logic                     hold;
   fcsl_op_t                 cmd_op;
   fcsl_mode_t               cmd_mode;

   assign cmd_op   = fcsl_op_t'(avs_writedata_i[2:0]);
   assign cmd_mode = fcsl_mode_t'(avs_writedata_i[4:3]);
   assign do_wr    = avs_write_i && !waitreq && (avs_byteenable_i == 4'hf);
   // A new command waits on the bus while one is still in flight.
   assign hold     = avs_write_i && (avs_address_i == `FCSL_OFS_CMD) && busy;

   always_comb
   begin
      next_waitreq    = !((avs_read_i || avs_write_i) && waitreq && !hold);
      next_readdata   = readdata;
      next_req        = 1'b0;
      next_op         = op;
      next_mode       = mode;
      next_nv_t       = nv_t;
      next_addr       = addr;
      next_wdata      = wdata;
      next_busy       = busy;
      next_err        = err;
      next_expect_cnt = expect_cnt;
      next_elapsed    = elapsed;
      next_last_cnt   = last_cnt;
      next_rdata      = rdata;
      next_code_v     = code_v;
      next_code_nv    = code_nv;
      if (avs_read_i && waitreq)
      begin
         unique case (avs_address_i)
            `FCSL_OFS_ADDR: next_readdata = {7'h00, addr};
            `FCSL_OFS_STAT: next_readdata = {8'h00, rdata, 2'h0, last_cnt,
                                             4'h0, code_v, err, busy};
            default:        next_readdata = 32'h00000000;
         endcase
      end
      if (do_wr && avs_address_i == `FCSL_OFS_ADDR)
      begin
         next_addr = avs_writedata_i[`FCSL_ADDR_W-1:0];
      end
      if (do_wr && avs_address_i == `FCSL_OFS_STAT && avs_writedata_i[1])
      begin
         next_err = 1'b0;
      end
      if (do_wr && avs_address_i == `FCSL_OFS_CMD)
      begin
         next_req   = 1'b1;
         next_op    = cmd_op;
         next_mode  = cmd_mode;
         next_nv_t  = avs_writedata_i[5];
         next_wdata = {avs_writedata_i[15:11], 3'h0};                     // [RULE_07]
         next_busy  = 1'b1;
         next_elapsed = 6'h00;
         next_expect_cnt = fcsl_dummy(cmd_op, cmd_mode, code_v,
                                      avs_writedata_i[5]);     // [RULE_08] [RULE_12] [RULE_13]
         if (cmd_op == FCSL_OP_WR_REG && avs_writedata_i[5])
            next_code_nv = avs_writedata_i[15:14];
         else if (cmd_op == FCSL_OP_WR_REG)
            next_code_v = avs_writedata_i[15:14];                         // [RULE_15]
         else if (cmd_op == FCSL_OP_RELOAD)
            next_code_v = code_nv;
      end
      else if (busy)
      begin
         next_elapsed = elapsed + 6'h01;
         if (link.rsp)
         begin
            next_busy     = 1'b0;
            next_rdata    = link.rdata;
            next_last_cnt = elapsed - 6'h01;
            // Set wins over a clear in the same cycle.
            if (elapsed != expect_cnt + 6'h01)
               next_err = 1'b1;                                           // [RULE_14]
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         waitreq <= 1'b1;
         readdata <= 32'h00000000;
         req <= 1'b0;
         op <= FCSL_OP_RD_ANY;
         mode <= FCSL_MODE_SPI;
         nv_t <= 1'b0;
         addr <= '0;
         wdata <= 8'h00;
         busy <= 1'b0;
         err <= 1'b0;
         expect_cnt <= 6'h00;
         elapsed <= 6'h00;
         last_cnt <= 6'h00;
         rdata <= 8'h00;
         code_v <= 2'h0;
         code_nv <= 2'h0;
      end
      else
      begin
         waitreq <= next_waitreq;
         readdata <= next_readdata;
         req <= next_req;
         op <= next_op;
         mode <= next_mode;
         nv_t <= next_nv_t;
         addr <= next_addr;
         wdata <= next_wdata;
         busy <= next_busy;
         err <= next_err;
         expect_cnt <= next_expect_cnt;
         elapsed <= next_elapsed;
         last_cnt <= next_last_cnt;
         rdata <= next_rdata;
         code_v <= next_code_v;
         code_nv <= next_code_nv;
      end
   end

   assign link.req          = req;
   assign link.op           = op;
   assign link.mode         = mode;
   assign link.nv_target    = nv_t;
   assign link.addr         = addr;
   assign link.wdata        = wdata;
   assign avs_readdata_o    = readdata;
   assign avs_waitrequest_o = waitreq;

endmodule

// >>> fcsl_asserts.sv
/*
 * Checker for the link between the host end and the device end.
 * Assumes instantiation beside the link interface, with every signal joined by name.
 */
`timescale 1ns/1ns
module fcsl_asserts
   import fcsl_pkg::*;
(
   input logic        clk_sys_i,
   input logic        nrst_i,
   input logic        req,
   input fcsl_op_t    op,
   input fcsl_mode_t  mode,
   input logic        nv_target,
   input logic [7:0]  wdata,
   input logic        rsp,
   input logic [7:0]  rdata
);
   logic [5:0]  cnt;
   logic        pend;
   logic [7:0]  nv_m;
   logic [7:0]  vol_m;
   fcsl_op_t    lop;
   fcsl_mode_t  lmode;
   logic        lnv;
   logic [1:0]  lcode;
   logic        rd;
   logic [5:0]  spi_n;

   // A non-volatile register read has a fixed count, so it is kept out of the coded group.
   assign rd = (lop == FCSL_OP_RD_ANY && !lnv) || lop == FCSL_OP_RD_DYB || lop == FCSL_OP_RD_STAT;
   assign spi_n = (lcode == 2'h3) ? 6'h02 :
                  (lcode == 2'h0 || (lcode == 2'h1 && lop == FCSL_OP_RD_STAT)) ? 6'h00 : 6'h01;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt <= 6'h00;
         pend <= 1'b0;
         nv_m <= 8'h00;
         vol_m <= 8'h00;
      end
      else if (req)
      begin
         cnt <= 6'h00;
         pend <= 1'b1;
         if (op == FCSL_OP_WR_REG && nv_target)
            nv_m <= wdata;
         if (op == FCSL_OP_WR_REG && !nv_target)
            vol_m <= {wdata[7:4], vol_m[3], wdata[2:0]};
         if (op == FCSL_OP_RELOAD)
            vol_m <= nv_m;
      end
      else
      begin
         cnt <= cnt + 6'h01;
         pend <= pend && !rsp;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (req)
      begin
         lop <= op;
         lmode <= mode;
         lnv <= nv_target;
         lcode <= vol_m[7:6];
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence s_answer;
      rsp && pend;
   endsequence

   sequence s_wait;
      ##[1:34] rsp;
   endsequence

   a_uid_wait: assert property (s_answer ##0 lop == FCSL_OP_RD_UID |-> cnt == 6'h20)
      else $error("unique-id read answered at the wrong cycle");
   a_crc_wait: assert property (s_answer ##0 lop == FCSL_OP_RD_CRC |-> cnt == 6'h08)
      else $error("crc read answered at the wrong cycle");
   a_octal_wait: assert property (s_answer ##0 (rd && lmode != FCSL_MODE_SPI) |-> cnt == 6'h03 + 6'(lcode))
      else $error("octal register read answered at the wrong cycle");
   a_spi_wait: assert property (s_answer ##0 (rd && lmode == FCSL_MODE_SPI) |-> cnt == spi_n)
      else $error("single-wire register read answered at the wrong cycle");
   a_reg_readback: assert property (s_answer ##0 lop == FCSL_OP_RD_ANY |-> rdata == (lnv ? nv_m : vol_m))
      else $error("register read returned a wrong byte");
   a_rsvd_zero: assert property (req && op == FCSL_OP_WR_REG |-> wdata[2:0] == 3'h0)
      else $error("reserved bits written as nonzero");
   a_answer_due: assert property (req |-> s_wait)
      else $error("request not answered in time");
   a_no_stray: assert property (rsp |-> pend && !req)
      else $error("answer without an open request");
endmodule

// >>> tb_flash_cfg_sector_latency.sv
/*
 * Testbench joining host and device ends through the link interface.
 * Assumes fcsl_pkg and fcsl_cfg.svh are compiled first; the host is driven over Avalon-MM.
 */
`timescale 1ns/1ns
`include "fcsl_cfg.svh"
module tb_flash_cfg_sector_latency
   import fcsl_pkg::*;
;
   logic                     clk_sys_i;
   logic                     nrst_i;
   logic                     split_sel;
   logic                     top_sel;
   logic [`FCSL_ADDR_W-1:0]  lk_addr;
   logic                     lk_small;
   logic                     uniform;
   logic [1:0]               lat_code;
   logic                     erase_p;
   logic [`FCSL_ADDR_W-1:0]  erase_addr;
   logic [3:0]               av_addr;
   logic                     av_rd;
   logic                     av_wr;
   logic [31:0]              av_wdata;
   logic [3:0]               av_be;
   logic [31:0]              av_rdata;
   logic                     av_wait;
   logic [31:0]              d;
   int                       failures = 0;
   int                       cmp_count = 0;
   int                       n_erase = 0;
   int                       c;
   int                       m;
   int                       o;
   // Entries are {split, top, expected hit, address}.
   localparam logic [27:0]   LK [8] = '{28'h2000000, 28'h201ffff, 28'h0020000, 28'h7fe0000,
                                        28'h5fdffff, 28'ha00ffff, 28'h8010000, 28'hbff0000};

   fcsl_link_if link_if();

   fcsl_device fcsl_device_inst
   (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link_if), .split_select_i(split_sel),
      .top_bottom_select_i(top_sel), .lookup_addr_i(lk_addr), .lookup_small_o(lk_small),
      .layout_uniform_o(uniform), .latency_code_o(lat_code), .erase_small_o(erase_p),
      .erase_addr_o(erase_addr)
   );

   fcsl_host fcsl_host_inst
   (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link_if), .avs_address_i(av_addr),
      .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
      .avs_byteenable_i(av_be), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait)
   );

   fcsl_asserts fcsl_asserts_inst
   (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req(link_if.req), .op(link_if.op),
      .mode(link_if.mode), .nv_target(link_if.nv_target), .wdata(link_if.wdata),
      .rsp(link_if.rsp), .rdata(link_if.rdata)
   );

   initial
   begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i)
      if (erase_p === 1'b1)
         n_erase <= n_erase + 1;

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Holds the request until the edge that samples waitrequest low; a hang ends the run.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rv);
      int i;
      @(posedge clk_sys_i);
      av_rd <= !w;
      av_wr <= w;
      av_addr <= a;
      av_wdata <= wd;
      for (i = 0; i < 60; i++)
      begin
         @(posedge clk_sys_i);
         if (av_wait === 1'b0)
            break;
      end
      rv = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      if (i == 60)
      begin
         failures++;
         test_done();
      end
   endtask

   // Launches one link transaction and polls status until it is no longer busy.
   task automatic run(input fcsl_op_t op, input fcsl_mode_t md, input logic nv,
                      input logic [7:0] wd);
      int i;
      bus(1'b1, 4'h0, {16'h0000, wd, 2'h0, nv, md, op}, d);
      for (i = 0; i < 60; i++)
      begin
         bus(1'b0, 4'h8, 32'h0, d);
         if (d[0] === 1'b0)
            return;
      end
      failures++;
      test_done();
   endtask

   function automatic logic [5:0] exp_n(input fcsl_op_t op, input fcsl_mode_t md,
                                        input logic [1:0] cd);
      if (op == FCSL_OP_RD_UID)
         return 6'h20;
      if (op == FCSL_OP_RD_CRC)
         return 6'h08;
      if (md != FCSL_MODE_SPI)
         return 6'h03 + 6'(cd);
      if (cd == 2'h0 || (cd == 2'h1 && op == FCSL_OP_RD_STAT))
         return 6'h00;
      return (cd == 2'h3) ? 6'h02 : 6'h01;
   endfunction

   initial
   begin
      nrst_i = 1'b0;
      split_sel = 1'b0;
      top_sel = 1'b0;
      lk_addr = '0;
      av_addr = 4'h0;
      av_rd = 1'b0;
      av_wr = 1'b0;
      av_wdata = 32'h0;
      av_be = 4'hf;
      repeat (3) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      bus(1'b0, 4'h8, 32'h0, d);
      chk(d, 32'h0);
      chk(32'({uniform, lat_code}), 32'h0);
      $display("test reset done");
      for (c = 0; c < 4; c++)
      begin
         run(FCSL_OP_WR_REG, FCSL_MODE_SPI, 1'b0, {2'(c), 6'h07});
         chk(32'(lat_code), 32'(c));
         for (m = 0; m < 3; m++)
            for (o = 0; o < 5; o++)
            begin
               run(fcsl_op_t'(3'(o)), fcsl_mode_t'(2'(m)), 1'b0, 8'h00);
               chk(32'(d[13:8]), 32'(exp_n(fcsl_op_t'(3'(o)), fcsl_mode_t'(2'(m)), 2'(c))));
               chk(32'(d[1:0]), 32'h0);
            end
         run(FCSL_OP_RD_ANY, FCSL_MODE_SPI, 1'b0, 8'h00);
         chk(32'({d[23:16], d[3:2]}), 32'({2'(c), 6'h00, 2'(c)}));
      end
      $display("test latency done");
      run(FCSL_OP_WR_REG, FCSL_MODE_SPI, 1'b1, 8'h08);
      run(FCSL_OP_RD_ANY, FCSL_MODE_SPI, 1'b1, 8'h00);
      chk(32'({d[23:16], 2'h0, d[13:8]}), 32'h0808);
      run(FCSL_OP_WR_REG, FCSL_MODE_SPI, 1'b0, 8'h08);
      run(FCSL_OP_RD_ANY, FCSL_MODE_SPI, 1'b0, 8'h00);
      chk(32'({uniform, d[23:16]}), 32'h0);
      bus(1'b1, 4'h4, 32'h0000100, d);
      run(FCSL_OP_ERASE_SMALL, FCSL_MODE_SPI, 1'b0, 8'h00);
      chk(32'(n_erase), 32'h1);
      chk(32'(erase_addr), 32'h100);
      run(FCSL_OP_RELOAD, FCSL_MODE_SPI, 1'b0, 8'h00);
      chk(32'(uniform), 32'h1);
      run(FCSL_OP_ERASE_SMALL, FCSL_MODE_SPI, 1'b0, 8'h00);
      chk(32'({n_erase[1:0], lk_small}), 32'h2);
      run(FCSL_OP_WR_REG, FCSL_MODE_SPI, 1'b1, 8'h00);
      run(FCSL_OP_RELOAD, FCSL_MODE_SPI, 1'b0, 8'h00);
      chk(32'(uniform), 32'h0);
      $display("test layout done");
      for (c = 0; c < 8; c++)
      begin
         split_sel <= LK[c][27];
         top_sel <= LK[c][26];
         lk_addr <= LK[c][24:0];
         repeat (3) @(posedge clk_sys_i);
         chk(32'(lk_small), 32'(LK[c][25]));
      end
      $display("test lookup done");
      av_be <= 4'h3;
      run(FCSL_OP_WR_REG, FCSL_MODE_SPI, 1'b0, 8'hc0);
      av_be <= 4'hf;
      run(FCSL_OP_RD_ANY, FCSL_MODE_SPI, 1'b0, 8'h00);
      chk(32'({lat_code, d[23:16]}), 32'h0);
      bus(1'b0, 4'hc, 32'h0, d);
      chk(d, 32'h0);
      $display("test bus done");
      test_done();
   end
endmodule
